//--- design/spi_slave_command_port.sv
// Serial slave command port: pin filters, shifter and command decoder
`timescale 1ns/1ps
// How it works
// - On each filtered rising serial clock while selected, drive shifter MSB out.
// - On each filtered falling serial clock while selected, shift data in.
// - Deselected: clock and data ignored, data out disabled; select active low.
// - On select assertion, load shifter with answer to previous request.
// - On release, rise and fall counts must match and be multiples of 16.
// - With good counts, validate the 16-bit word; invalid gives error, else decode.
// - Clock and data accepted only after three equal oscillator samples.
// - Select accepted only after two equal oscillator samples.
// - Each answer returns one transfer after its request.
// - First word after reset is the primary status register.
// - Words carry odd parity in bit 0; received parity checked by default.
// - Parity enable cleared makes parity don't care for variable commands.
// - Transmitted words always carry correct odd parity.
// - Fixed commands need correct parity even with checking disabled.
// - Error discards request, sets sticky flag, answer carries error marker.
// - Unknown word, wrong mode, bad address or busy secondary read is error.
// - Enter configuration from default or error; verify and exit from configuration.
// - Read returns register at the 5-bit address as next answer.
// - Write-high loads upper buffer byte only.
// - Write-low fills low byte, commits buffer to address, clears buffer.
// - No-op only gets checks and the status answer.
// - Fixed codes 1880, 1140, 1220, 1410 answered with status.
// - Read is address shifted by 7 ORed with 002a and parity.
// - Write-high 4400 with byte shifted 1; write-low a000 with address and data.
module spi_slave_command_port
  import spi_cmd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        primaryRcOscillator,
  input  wire logic        chipSelectN,
  input  wire logic        serialClock,
  input  wire logic        serialDataIn,
  output logic             serialDataOut,
  output logic             serialDataOutEn,
  input  wire logic        parityCheckEnable,
  input  wire logic [14:0] statusPayload,
  input  wire logic        forceErrorMode,
  input  wire logic        secondaryBusy,
  input  wire logic [14:0] regRdData,
  input  wire logic        clearSerialError,
  output logic [2:0]       opMode,
  output logic             serialErrorFlag,
  output logic             regRdStb,
  output logic [4:0]       regRdAddr,
  output logic             regWrStb,
  output logic [4:0]       regWrAddr,
  output logic [15:0]      regWrData
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic oddPar(input logic [14:0] p);
    oddPar = ~(^p);
  endfunction : oddPar

  function automatic logic allSame(input logic [2:0] h, input logic two);
    allSame = two ? (h[0] == h[1]) : ((h[0] == h[1]) && (h[1] == h[2]));
  endfunction : allSame

  // ----------------------------------------------------------------------
  // Pin synchronisers and glitch filters (oscillator domain)
  // ----------------------------------------------------------------------
  logic [1:0] csS_q, ckS_q, diS_q;   // Two-flop synchronisers
  logic [2:0] csH_q, ckH_q, diH_q;
  logic       csF_q, ckF_q, diF_q, ckPrev_q, csPrev_q;

  always_ff @(posedge primaryRcOscillator or posedge rst) begin
    if (rst) begin
      csS_q <= 2'h3;
      ckS_q <= 2'h0;
      diS_q <= 2'h3;
    end else begin
      csS_q <= {csS_q[0], chipSelectN};
      ckS_q <= {ckS_q[0], serialClock};
      diS_q <= {diS_q[0], serialDataIn};
    end
  end

  always_ff @(posedge primaryRcOscillator or posedge rst) begin
    if (rst) begin
      csH_q    <= 3'h7;
      ckH_q    <= 3'h0;
      diH_q    <= 3'h7;
      csF_q    <= 1'b1;
      ckF_q    <= 1'b0;
      diF_q    <= 1'b1;
      ckPrev_q <= 1'b0;
      csPrev_q <= 1'b1;
    end else begin
      csH_q    <= {csH_q[1:0], csS_q[1]};
      ckH_q    <= {ckH_q[1:0], ckS_q[1]};
      diH_q    <= {diH_q[1:0], diS_q[1]};
      if (allSame(csH_q, 1'b1)) csF_q <= csH_q[0];
      if (allSame(ckH_q, 1'b0)) ckF_q <= ckH_q[0];
      if (allSame(diH_q, 1'b0)) diF_q <= diH_q[0];
      ckPrev_q <= ckF_q;
      csPrev_q <= csF_q;
    end
  end

  logic selected, csAssert, csRelease, ckRise, ckFall;
  assign selected  = ~csF_q;
  assign csAssert  = csPrev_q & ~csF_q;
  assign csRelease = ~csPrev_q & csF_q;
  assign ckRise    = selected & ~csAssert & ~ckPrev_q & ckF_q;
  assign ckFall    = selected & ~csAssert & ckPrev_q & ~ckF_q;

  // ----------------------------------------------------------------------
  // Shifter and edge counters (oscillator domain)
  // ----------------------------------------------------------------------
  logic [15:0]           shift_q, ansLocal_q, rxWord_q;
  logic [EDGE_CNT_W-1:0] riseCnt_q, fallCnt_q;
  logic                  txBit_q, txOe_q, edgeErr_q, frmTog_q;
  logic [2:0]            ansTogS_q;   // [0],[1] sync pair, [2] history

  always_ff @(posedge primaryRcOscillator or posedge rst) begin
    if (rst) begin
      shift_q   <= ANSWER_RST;
      riseCnt_q <= '0;
      fallCnt_q <= '0;
      txBit_q   <= 1'b0;
      txOe_q    <= 1'b0;
    end else begin
      txOe_q <= selected;
      if (csAssert) begin
        shift_q   <= ansLocal_q;
        txBit_q   <= ansLocal_q[15];
        riseCnt_q <= '0;
        fallCnt_q <= '0;
      end else if (ckRise) begin
        txBit_q   <= shift_q[15];
        riseCnt_q <= riseCnt_q + 1'b1;
      end else if (ckFall) begin
        // sample on falling edge; old bits chain onward for daisy use
        shift_q   <= {shift_q[14:0], diF_q};
        fallCnt_q <= fallCnt_q + 1'b1;
      end
    end
  end

  // Frame handed to the system clock by a toggle; data holds until next release
  always_ff @(posedge primaryRcOscillator or posedge rst) begin
    if (rst) begin
      rxWord_q  <= '0;
      edgeErr_q <= 1'b0;
      frmTog_q  <= 1'b0;
    end else if (csRelease) begin
      rxWord_q  <= shift_q;
      // edge counts equal, non-zero and multiples of 16
      edgeErr_q <= (riseCnt_q != fallCnt_q) || (fallCnt_q[3:0] != 4'h0)
                   || (fallCnt_q == '0);
      frmTog_q  <= ~frmTog_q;
    end
  end

  logic [15:0] ansWord_q;
  logic        ansTog_q;

  // answer word pulled in when its toggle arrives
  always_ff @(posedge primaryRcOscillator or posedge rst) begin
    if (rst) begin
      ansTogS_q  <= 3'h0;
      ansLocal_q <= ANSWER_RST;
    end else begin
      ansTogS_q <= {ansTogS_q[1], ansTogS_q[0], ansTog_q};
      if (ansTogS_q[2] != ansTogS_q[1]) ansLocal_q <= ansWord_q;
    end
  end

  assign serialDataOut   = txBit_q;
  assign serialDataOutEn = txOe_q;

  // ----------------------------------------------------------------------
  // Command decode (system clock)
  // ----------------------------------------------------------------------
  logic [2:0] frmS_q;   // [0],[1] sync pair, [2] history
  logic       frameNew;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) frmS_q <= 3'h0;
    else     frmS_q <= {frmS_q[1], frmS_q[0], frmTog_q};
  end
  assign frameNew = frmS_q[2] ^ frmS_q[1];

  mode_t       mode_q;
  logic [15:0] wbuf_q;
  logic        isFixed, isRead, isWrHi, isWrLo, parOk, varParOk, addrOk;
  logic        modeOk, errNow;
  logic [4:0]  addr;

  assign addr     = rxWord_q[ADDR_LSB +: 5];
  // odd parity across the whole word
  assign parOk    = ^rxWord_q;
  // variable commands skip parity when checking is off
  assign varParOk = parOk | ~parityCheckEnable;
  assign isFixed  = (rxWord_q == CMD_ENTER_CFG) || (rxWord_q == CMD_ENTER_VER)
                    || (rxWord_q == CMD_EXIT_CFG) || (rxWord_q == CMD_NOOP);
  assign isRead   = ((rxWord_q & READ_MASK) == READ_CODE);
  assign isWrHi   = ((rxWord_q & WRHI_MASK) == WRHI_CODE);
  assign isWrLo   = ((rxWord_q & WRLO_MASK) == WRLO_CODE);

  // address ranges and busy secondary read
  always_comb begin
    addrOk = 1'b1;
    if (isRead)
      addrOk = RD_ADDR_OK[addr] && !((addr >= SEC_ADDR_BASE) && secondaryBusy);
    else if (isWrLo)
      addrOk = (mode_q == MODE_CONFIG) ? WR_ADDR_OK_CFG[addr] : WR_ADDR_OK_RUN[addr];
  end

  // mode gating of the fixed commands
  always_comb begin
    case (rxWord_q)
      CMD_ENTER_CFG: modeOk = (mode_q == MODE_DEFAULT) || (mode_q == MODE_ERROR);
      CMD_ENTER_VER: modeOk = (mode_q == MODE_CONFIG);
      CMD_EXIT_CFG:  modeOk = (mode_q == MODE_CONFIG);
      default:       modeOk = 1'b1;
    endcase
  end

  // word checked only after good counts
  // fixed codes include their parity bit
  assign errNow = frameNew & (edgeErr_q | ~(
                    (isFixed & modeOk) | ((isRead | isWrHi | isWrLo) & varParOk & addrOk)));

  logic takeCmd;
  assign takeCmd = frameNew & ~errNow;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_DEFAULT;
    end else if (forceErrorMode) begin
      mode_q <= MODE_ERROR;
    end else if (takeCmd) begin
      case (rxWord_q)
        CMD_ENTER_CFG: mode_q <= MODE_CONFIG;
        CMD_ENTER_VER: mode_q <= MODE_VERIFY;
        CMD_EXIT_CFG:  mode_q <= MODE_CONFIGURED;
        default:       mode_q <= mode_q;
      endcase
    end
  end

  logic errFlag_q;

  // sticky flag, a new error wins over the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)                   errFlag_q <= 1'b0;
    else if (errNow)           errFlag_q <= 1'b1;
    else if (clearSerialError) errFlag_q <= 1'b0;
  end

  logic        wrStb_q;
  logic [4:0]  wrAddr_q;
  logic [15:0] wrData_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wbuf_q   <= WBUF_RST;
      wrStb_q  <= 1'b0;
      wrAddr_q <= '0;
      wrData_q <= '0;
    end else begin
      wrStb_q <= 1'b0;
      if (takeCmd && isWrHi) begin
        wbuf_q[15:8] <= rxWord_q[DATA_LSB +: 8];
      end else if (takeCmd && isWrLo) begin
        wrStb_q  <= 1'b1;
        wrAddr_q <= addr;
        wrData_q <= {wbuf_q[15:8], rxWord_q[DATA_LSB +: 6], 2'b00};
        wbuf_q   <= WBUF_RST;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Answer builder (system clock)
  // ----------------------------------------------------------------------
  logic       rdStb_q, rdWait_q, boot_q, ansPub_q;
  logic [4:0] rdAddr_q;
  logic [14:0] errPayload;
  assign errPayload = statusPayload | (15'h1 << ERR_MARK_BIT);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdStb_q   <= 1'b0;
      rdWait_q  <= 1'b0;
      rdAddr_q  <= '0;
      boot_q    <= 1'b1;
      ansPub_q  <= 1'b0;
      ansTog_q  <= 1'b0;
      ansWord_q <= ANSWER_RST;
    end else begin
      rdStb_q  <= 1'b0;
      rdWait_q <= rdStb_q;
      ansPub_q <= 1'b0;
      if (takeCmd && isRead) begin
        rdStb_q  <= 1'b1;
        rdAddr_q <= addr;
      end else if (rdWait_q) begin
        ansWord_q <= {regRdData, oddPar(regRdData)};
        ansTog_q  <= ~ansTog_q;
        ansPub_q  <= 1'b1;
      end else if (frameNew || boot_q) begin
        // status answer for no-op and other commands
        // error marker on a refused request
        ansWord_q <= errNow ? {errPayload, oddPar(errPayload)}
                            : {statusPayload, oddPar(statusPayload)};
        ansTog_q  <= ~ansTog_q;
        ansPub_q  <= 1'b1;
        boot_q    <= 1'b0;
      end
    end
  end

  assign opMode          = mode_q;
  assign serialErrorFlag = errFlag_q;
  assign regRdStb        = rdStb_q;
  assign regRdAddr       = rdAddr_q;
  assign regWrStb        = wrStb_q;
  assign regWrAddr       = wrAddr_q;
  assign regWrData       = wrData_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_errAnswer;
    ansPub_q && ansWord_q[ERR_MARK_BIT + 1];
  endsequence

  sequence s_commit;
    wrStb_q ##1 (wbuf_q == WBUF_RST);
  endsequence

  a_out_release: assert property (@(posedge primaryRcOscillator) disable iff (rst)
    csF_q |=> !txOe_q) else $error("data out driven while deselected");

  a_answer_load: assert property (@(posedge primaryRcOscillator) disable iff (rst)
    csAssert |=> (shift_q == $past(ansLocal_q))) else $error("answer not loaded");

  a_edge_count: assert property (@(posedge primaryRcOscillator) disable iff (rst)
    csRelease && (riseCnt_q != fallCnt_q) |=> edgeErr_q) else $error("edge mismatch missed");

  a_clock_filter: assert property (@(posedge primaryRcOscillator) disable iff (rst)
    $changed(ckF_q) |-> ($past(ckS_q[1], 2) == ckF_q) && ($past(ckS_q[1], 3) == ckF_q)
      && ($past(ckS_q[1], 4) == ckF_q)) else $error("clock glitch passed");

  a_select_filter: assert property (@(posedge primaryRcOscillator) disable iff (rst)
    $changed(csF_q) |-> ($past(csS_q[1], 2) == csF_q) && ($past(csS_q[1], 3) == csF_q))
    else $error("select glitch passed");

  a_parity_out: assert property (@(posedge sys_clk) disable iff (rst)
    ansPub_q |-> (^ansWord_q)) else $error("answer parity wrong");

  a_error_mark: assert property (@(posedge sys_clk) disable iff (rst)
    errNow |=> errFlag_q ##0 s_errAnswer) else $error("error not reported");

  a_enter_config: assert property (@(posedge sys_clk) disable iff (rst)
    takeCmd && !forceErrorMode && (rxWord_q == CMD_ENTER_CFG) |=> (mode_q == MODE_CONFIG))
    else $error("configuration not entered");

  a_read_answer: assert property (@(posedge sys_clk) disable iff (rst)
    takeCmd && isRead |=> rdStb_q ##2 (ansPub_q && ansWord_q[15:1] == $past(regRdData)))
    else $error("read answer wrong");

  a_write_commit: assert property (@(posedge sys_clk) disable iff (rst)
    takeCmd && isWrLo |=> s_commit) else $error("write-low not committed");

endmodule : spi_slave_command_port

//--- design/spi_cmd_pkg.sv
// Constants and types shared by the serial command port
package spi_cmd_pkg;

  // ----------------------------------------------------------------------
  // Word format
  // ----------------------------------------------------------------------
  localparam int          WORD_W       = 16;
  localparam int          EDGE_CNT_W   = 8;
  localparam int          ERR_MARK_BIT = 14;   // Answer payload bit that flags an error

  // ----------------------------------------------------------------------
  // Fixed request codes and command masks
  // ----------------------------------------------------------------------
  localparam logic [15:0] CMD_ENTER_CFG   = 16'h1880;
  localparam logic [15:0] CMD_ENTER_VER   = 16'h1140;
  localparam logic [15:0] CMD_EXIT_CFG    = 16'h1220;
  localparam logic [15:0] CMD_NOOP        = 16'h1410;
  localparam logic [15:0] READ_MASK       = 16'hf07e;
  localparam logic [15:0] READ_CODE       = 16'h002a;
  localparam logic [15:0] WRHI_MASK       = 16'hfe00;
  localparam logic [15:0] WRHI_CODE       = 16'h4400;
  localparam logic [15:0] WRLO_MASK       = 16'hf000;
  localparam logic [15:0] WRLO_CODE       = 16'ha000;
  localparam int          ADDR_LSB        = 7;
  localparam int          DATA_LSB        = 1;

  // ----------------------------------------------------------------------
  // Address map limits
  // ----------------------------------------------------------------------
  localparam logic [31:0] RD_ADDR_OK      = 32'hffff_ffff;
  localparam logic [31:0] WR_ADDR_OK_CFG  = 32'h0000_ffff;
  localparam logic [31:0] WR_ADDR_OK_RUN  = 32'h0000_000f;
  localparam logic [4:0]  SEC_ADDR_BASE   = 5'h10;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] ANSWER_RST      = 16'h0001;
  localparam logic [15:0] WBUF_RST        = 16'h0000;

  // ----------------------------------------------------------------------
  // Operating modes, Gray along default, configuration, configured
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_DEFAULT    = 3'h0,
    MODE_CONFIG     = 3'h1,
    MODE_CONFIGURED = 3'h3,
    MODE_VERIFY     = 3'h2,
    MODE_ERROR      = 3'h4
  } mode_t;

endpackage : spi_cmd_pkg

//--- test/spi_master_model.sv
// Behavioural serial master driving the command port pins
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic linkClk,
  input  wire logic serialDataOut,
  input  wire logic serialDataOutEn,
  output logic      chipSelectN,
  output logic      serialClock,
  output logic      serialDataIn
);
  logic lastOut = 1'b0;
  logic outSeen;

  // ------------------------------------------------------------
  // Line as seen by the master
  // ------------------------------------------------------------
  // released output line
  // No pull on this line, so a released line toggles each cycle
  assign outSeen = serialDataOutEn ? serialDataOut : ~lastOut;

  always @(posedge linkClk) begin
    lastOut <= outSeen;
  end

  // idle pins
  // Clock stands low between frames, data in sits at its pull-up level
  initial begin
    chipSelectN  = 1'b1;
    serialClock  = 1'b0;
    serialDataIn = 1'b1;
  end

  // ------------------------------------------------------------
  // One transfer of n bits, MSB first
  // ------------------------------------------------------------
  task automatic xfer(input logic [31:0] tx, input int n, input int gl,
                      output logic [31:0] rx);
    rx = '0;
    @(posedge linkClk);
    chipSelectN <= 1'b0;
    repeat (12) @(posedge linkClk);
    for (int i = n - 1; i >= 0; i--) begin
      // shift on rise, sample on fall
      serialDataIn <= tx[i];
      serialClock  <= 1'b1;
      repeat (8) @(posedge linkClk);
      rx = {rx[30:0], outSeen};
      // mode 2 holds back the last fall so the edge counts differ
      if (!(gl == 2 && i == 0)) serialClock <= 1'b0;
      repeat (8) @(posedge linkClk);
      // one-cycle clock glitch inside the low phase
      if (gl == 1 && i == n - 4) begin
        serialClock <= 1'b1;
        @(posedge linkClk);
        serialClock <= 1'b0;
        repeat (6) @(posedge linkClk);
      end
    end
    chipSelectN  <= 1'b1;
    serialDataIn <= 1'b1;
    // Clock parks low only after the select is released
    repeat (8) @(posedge linkClk);
    serialClock  <= 1'b0;
  endtask : xfer
endmodule : spi_master_model

//--- test/spi_slave_command_port_tb.sv
// Self-checking bench for the serial command port
`timescale 1ns/1ps
module spi_slave_command_port_tb;
  import spi_cmd_pkg::*;
  logic        sys_clk             = 1'b0;
  logic        primaryRcOscillator = 1'b0;
  logic        rst                 = 1'b1;
  logic        parityCheckEnable   = 1'b1;
  logic [14:0] statusPayload       = 15'h1234;
  logic        forceErrorMode      = 1'b0;
  logic        secondaryBusy       = 1'b0;
  logic [14:0] regRdData           = 15'h0000;
  logic        clearSerialError    = 1'b0;
  logic        chipSelectN, serialClock, serialDataIn, serialDataOut, serialDataOutEn;
  logic        serialErrorFlag, regRdStb, regWrStb;
  logic [2:0]  opMode;
  logic [4:0]  regRdAddr, regWrAddr, wrAddr;
  logic [15:0] regWrData, wrData, expAns, sA, eA;
  int          nFail = 0, compares = 0, wrSeen = 0, rdSeen = 0, cycles = 0;

  // ------------------------------------------------------------
  // Clocks, instances and far-side responders
  // ------------------------------------------------------------
  initial forever #20 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #16 primaryRcOscillator = ~primaryRcOscillator;
  end

  spi_slave_command_port u_dut (.sys_clk, .rst, .primaryRcOscillator, .chipSelectN,
    .serialClock, .serialDataIn, .serialDataOut, .serialDataOutEn, .parityCheckEnable,
    .statusPayload, .forceErrorMode, .secondaryBusy, .regRdData, .clearSerialError,
    .opMode, .serialErrorFlag, .regRdStb, .regRdAddr, .regWrStb, .regWrAddr, .regWrData);

  spi_master_model u_master (.linkClk(primaryRcOscillator), .serialDataOut,
    .serialDataOutEn, .chipSelectN, .serialClock, .serialDataIn);

  always @(posedge sys_clk) begin
    regRdData <= {regRdAddr, 10'h2c5};
    if (regRdStb === 1'b1) rdSeen <= rdSeen + 1;
    if (regWrStb === 1'b1) begin
      wrSeen <= wrSeen + 1;
      wrAddr <= regWrAddr;
      wrData <= regWrData;
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] withPar(input logic [14:0] p);
    return {p, ~^p};
  endfunction : withPar

  function automatic logic [15:0] req(input logic [15:0] w);
    return {w[15:1], ~^w[15:1]};
  endfunction : req

  task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : checkWord

  task automatic checkBits(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : checkBits

  task automatic completeRun();
    $display("compares=%0d nFail=%0d", compares, nFail);
    if (nFail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : completeRun

  // Answer collected here belongs to the previous request
  task automatic cmd(input logic [15:0] w, input int n, input int gl,
                     input logic [15:0] nxt);
    logic [31:0] rx;
    u_master.xfer({16'h0000, w}, n, gl, rx);
    checkWord(rx[15:0], expAns >> (16 - n));
    expAns = nxt;
    repeat (20) @(posedge sys_clk);
    checkBits({2'b00, serialDataOutEn}, 3'h0);
  endtask : cmd

  task automatic errCheck();
    checkBits({2'b00, serialErrorFlag}, 3'h1);
    clearSerialError <= 1'b1;
    @(posedge sys_clk);
    clearSerialError <= 1'b0;
    repeat (2) @(posedge sys_clk);
    checkBits({2'b00, serialErrorFlag}, 3'h0);
  endtask : errCheck

  // Hang guard: the run needs about 4900 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 15000) begin
      nFail++;
      completeRun();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    sA     = withPar(statusPayload);
    eA     = withPar(statusPayload | 15'h4000);
    expAns = sA;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    cmd(CMD_NOOP, 16, 1'b0, sA);
    checkBits(opMode, MODE_DEFAULT);
    cmd(CMD_ENTER_CFG, 16, 1'b0, sA);
    checkBits(opMode, MODE_CONFIG);
    cmd(req(WRHI_CODE | 16'h0156), 16, 1'b0, sA);
    checkWord(16'(wrSeen), 16'h0000);
    cmd(req(WRLO_CODE | 16'h02aa), 16, 1'b0, sA);
    checkWord(wrData, 16'hab54);
    checkWord({11'h000, wrAddr}, 16'h0005);
    cmd(req(WRLO_CODE | 16'h02fe), 16, 1'b0, sA);
    checkWord(wrData, 16'h00fc);
    cmd(req(WRLO_CODE | 16'h0a00), 16, 1'b0, eA);
    checkWord(16'(wrSeen), 16'h0002);
    errCheck();
    cmd(req(READ_CODE | 16'h0900), 16, 1'b1, withPar({5'h12, 10'h2c5}));
    secondaryBusy <= 1'b1;
    cmd(req(READ_CODE | 16'h0980), 16, 1'b0, eA);
    secondaryBusy <= 1'b0;
    checkWord(16'(rdSeen), 16'h0001);
    errCheck();
    cmd(req(READ_CODE | 16'h0180) ^ 16'h0001, 16, 1'b0, eA);
    errCheck();
    parityCheckEnable <= 1'b0;
    cmd(req(READ_CODE | 16'h0180) ^ 16'h0001, 16, 1'b0, withPar({5'h03, 10'h2c5}));
    checkBits({2'b00, serialErrorFlag}, 3'h0);
    checkWord(16'(rdSeen), 16'h0002);
    cmd(CMD_NOOP ^ 16'h0001, 16, 1'b0, eA);
    errCheck();
    cmd(CMD_NOOP, 15, 1'b0, eA);
    errCheck();
    cmd(CMD_NOOP, 16, 2, eA);
    errCheck();
    cmd(16'hfffe, 16, 1'b0, eA);
    errCheck();
    cmd(CMD_EXIT_CFG, 16, 1'b0, sA);
    checkBits(opMode, MODE_CONFIGURED);
    cmd(req(WRLO_CODE | 16'h02aa), 16, 1'b0, eA);
    checkWord(16'(wrSeen), 16'h0002);
    errCheck();
    cmd(CMD_ENTER_VER, 16, 1'b0, eA);
    checkBits(opMode, MODE_CONFIGURED);
    errCheck();
    forceErrorMode <= 1'b1;
    @(posedge sys_clk);
    forceErrorMode <= 1'b0;
    repeat (2) @(posedge sys_clk);
    checkBits(opMode, MODE_ERROR);
    cmd(CMD_ENTER_CFG, 16, 1'b0, sA);
    checkBits(opMode, MODE_CONFIG);
    cmd(CMD_ENTER_VER, 16, 1'b0, sA);
    checkBits(opMode, MODE_VERIFY);
    cmd(CMD_NOOP, 16, 1'b0, sA);
    completeRun();
  end
endmodule : spi_slave_command_port_tb
